// *** bpswc_pkg.sv ***
// package: constants and types of the board power state and wake controller
package bpswc_pkg;
   // clock and press timing
   localparam int CLK_HZ    = 40_000_000;  // pclk rate
   localparam int TICK_HZ   = 1000;        // press timer resolution, 1 ms
   localparam int T_SHORT_S = 4;           // short press limit, seconds
   localparam int T_LONG_S  = 6;           // forced off hold, seconds
   localparam logic [15:0] TICK_CYC    = 16'(CLK_HZ / TICK_HZ);
   localparam logic [12:0] SHORT_TICKS = 13'(T_SHORT_S * TICK_HZ);
   localparam logic [12:0] LONG_TICKS  = 13'(T_LONG_S * TICK_HZ);
   // register byte offsets
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_SLEEP = 12'h004;
   localparam logic [11:0] OFS_STAT  = 12'h008;
   localparam logic [11:0] OFS_MASK  = 12'h00c;
   localparam logic [11:0] OFS_WSRC  = 12'h010;
   // control register fields and reset value
   localparam int CB_USB_EN  = 0;          // usb wake from s4/s5 allowed
   localparam int CB_DEEP    = 1;          // s4/s5 are the deep variant
   localparam int CB_RESTORE = 2;          // restore s0 after ac loss if it was on
   localparam int CB_BTN_SLP = 3;          // short press asks os for sleep
   localparam logic [3:0] CTRL_RST = 4'h0;
   // status / mask fields
   localparam int SB_SLPREQ = 0;           // button asked for sleep
   localparam int SB_WAKE   = 1;           // system woken by a source
   localparam int SB_FORCED = 2;           // fail-safe power-off done
   localparam int SB_ACRET  = 3;           // ac power came back
   // wake source positions
   localparam int WK_RTC  = 0;
   localparam int WK_LAN  = 1;
   localparam int WK_USB  = 2;
   localparam int WK_PCIE = 3;
   localparam int WK_IR   = 4;
   localparam int NWAKE   = 5;
   // state codes as read and written by software
   localparam logic [2:0] STC_S0 = 3'h0;
   localparam logic [2:0] STC_S3 = 3'h3;
   localparam logic [2:0] STC_S4 = 3'h4;
   localparam logic [2:0] STC_S5 = 3'h5;
   localparam logic [2:0] STC_G3 = 3'h7;
   // system power states
   typedef enum logic [4:0] {
      ST_S0 = 5'b00001,
      ST_S3 = 5'b00010,
      ST_S4 = 5'b00100,
      ST_S5 = 5'b01000,
      ST_G3 = 5'b10000
   } bpswc_state_e;
   // press timer state
   typedef struct packed {
      logic [15:0] div;
      logic [12:0] cnt;
      logic        held;
      logic        long_done;
      logic        short_rel;
      logic        long_hold;
   } bpswc_tmr_s;
   // controller state
   typedef struct packed {
      bpswc_state_e st;
      logic [3:0]   ctrl;
      logic [3:0]   stat;
      logic [3:0]   mask;
      logic [4:0]   wsrc;
      logic [4:0]   wk_prev;
      logic         after_g3;
      logic         last_on;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic         irq;
      logic         cpu_pwr;
      logic         ram_pwr;
      logic         cold_boot;
      logic         resume;
      logic         display_on;
   } bpswc_ctl_s;
endpackage

// *** bpswc_press_if.sv ***
// interface: press timing events from the press timer to the controller
`timescale 1ns/1ps
`default_nettype none
interface bpswc_press_if;
   logic short_rel;   // released before the short limit, one cycle
   logic long_hold;   // hold reached the long limit, one cycle
   modport timer (output short_rel, output long_hold);
   modport ctrl  (input short_rel, input long_hold);
endinterface
`default_nettype wire

// *** bpswc_sync.sv ***
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bpswc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // pins and clean levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1, s2, s3, q;
   } bpswc_sync_s;
   bpswc_sync_s r_reg, r_next;
   ////////////////////////////////////////////////////////////////////////////
   // s1 feeds s2 only; output moves when s2 and s3 agree
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.q  = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 | r_reg.s3));
   end
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) r_reg <= '0;
      else r_reg <= r_next;
   end
   assign q = r_reg.q;
endmodule // bpswc_sync
`default_nettype wire

// *** bpswc_press_timer.sv ***
// module: power switch press duration timer on a 1 ms tick
`timescale 1ns/1ps
`default_nettype none
module bpswc_press_timer #(
   parameter logic [15:0] TICK_CYC_P    = bpswc_pkg::TICK_CYC,
   parameter logic [12:0] SHORT_TICKS_P = bpswc_pkg::SHORT_TICKS,
   parameter logic [12:0] LONG_TICKS_P  = bpswc_pkg::LONG_TICKS
) (
   // clock and reset
   input  wire logic   pclk,
   input  wire logic   presetn,
   // clean switch level, high while pressed
   input  wire logic   press,
   // timing events
   bpswc_press_if.timer pif
);
   import bpswc_pkg::*;
   bpswc_tmr_s t_reg, t_next;
   ////////////////////////////////////////////////////////////////////////////
   // divider restarts at each press so the first tick is a full 1 ms
   always_comb begin
      t_next           = t_reg;
      t_next.short_rel = 1'b0;
      t_next.long_hold = 1'b0;
      if (press) begin
         if (!t_reg.held) begin
            // new press
            t_next.held      = 1'b1;
            t_next.div       = 16'h0000;
            t_next.cnt       = 13'h0000;
            t_next.long_done = 1'b0;
         end else if (t_reg.div == TICK_CYC_P - 16'h0001) begin
            t_next.div = 16'h0000;
            // saturate so a very long hold cannot wrap back to short
            if (t_reg.cnt < LONG_TICKS_P) t_next.cnt = t_reg.cnt + 13'h0001;
         end else begin
            t_next.div = t_reg.div + 16'h0001;
         end
         // long limit fires once per press, while still held
         if (t_reg.held && t_reg.cnt >= LONG_TICKS_P && !t_reg.long_done) begin
            t_next.long_hold = 1'b1;
            t_next.long_done = 1'b1;
         end
      end else if (t_reg.held) begin
         t_next.held = 1'b0;
         // holds between the limits end silently
         if (t_reg.cnt < SHORT_TICKS_P) t_next.short_rel = 1'b1;
      end
   end
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) t_reg <= '0;
      else t_reg <= t_next;
   end
   assign pif.short_rel = t_reg.short_rel;
   assign pif.long_hold = t_reg.long_hold;
   a_mid_hold_silent: assert property (@(posedge pclk) disable iff (!presetn)
      (t_reg.held && !press && t_reg.cnt >= SHORT_TICKS_P) |=> !t_reg.short_rel)
      else $error("release after short limit gave a short event");
endmodule // bpswc_press_timer
`default_nettype wire

// *** bpswc_top.sv ***
// module: board power state and wake controller with apb registers
//
// Contract
// - short press while off or asleep: wake
// - short press while working: request sleep
// - hold over six seconds working: soft-off
// - hold over six seconds asleep: soft-off
// - leaving soft-off always cold boots
// - suspend-to-disk removes processor power
// - switch and rtc wake from s3-s5
// - rtc wake leaves monitor asleep
// - network wake s3-s5, after g3, monitor dark
// - usb wakes s3; s4/s5 by option only
// - usb never wakes deep s4/s5
// - pcie wake s3/s4 only, monitor dark
// - infrared wakes s3-s5, not deep
// - radio requests never wake the system
// - network wake frame request powers up
// - after ac return restore s0 if it was on
`timescale 1ns/1ps
`default_nettype none
module bpswc_top #(
   parameter logic [15:0] TICK_CYC_P    = bpswc_pkg::TICK_CYC,
   parameter logic [12:0] SHORT_TICKS_P = bpswc_pkg::SHORT_TICKS,
   parameter logic [12:0] LONG_TICKS_P  = bpswc_pkg::LONG_TICKS
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // board pins
   input  wire logic        pwr_btn_n,
   input  wire logic        ac_present,
   input  wire logic        rtc_alarm,
   input  wire logic        network_wake,
   input  wire logic        usb_wake,
   input  wire logic        pcie_wake_n,
   input  wire logic        infrared_remote_wake,
   // power and boot controls
   output logic             cpu_pwr_en,
   output logic             ram_pwr_en,
   output logic             cold_boot,
   output logic             resume,
   output logic             display_on,
   // interrupt
   output logic             irq
);
   import bpswc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset value of all controller state: no power until ac is seen
   localparam bpswc_ctl_s CTL_RST = '{st: ST_G3, ctrl: CTRL_RST, default: '0};

   bpswc_ctl_s       q_reg;      // registered state
   bpswc_ctl_s       q_next;     // next state
   logic [1:0]       pin_s;      // clean {ac, pressed}
   logic [NWAKE-1:0] wk_s;       // clean wake levels
   logic [NWAKE-1:0] wk_edge;    // new wake requests this cycle
   logic [NWAKE-1:0] wake_ok;    // requests allowed in this state
   logic             ac_s;       // ac power present
   logic             s3, s4, s5; // sleep state decodes
   logic             sleeping;   // any of s3, s4, s5
   logic             acc;        // apb access completing
   logic             cmd_wr;     // sleep command write completing
   logic             quiet;      // no press event, ac present

   bpswc_press_if tm ();

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; radio requests have no input at all
   bpswc_sync #(.W(2)) u_sync_pin (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({ac_present, ~pwr_btn_n}),
      .q       (pin_s)
   );
   bpswc_sync #(.W(NWAKE)) u_sync_wake (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({infrared_remote_wake, ~pcie_wake_n, usb_wake,
                 network_wake, rtc_alarm}),
      .q       (wk_s)
   );
   // press duration timer
   bpswc_press_timer #(
      .TICK_CYC_P    (TICK_CYC_P),
      .SHORT_TICKS_P (SHORT_TICKS_P),
      .LONG_TICKS_P  (LONG_TICKS_P)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .press   (pin_s[0]),
      .pif     (tm.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decodes shared by the next-state logic and the checks
   assign ac_s     = pin_s[1];
   assign s3       = (q_reg.st == ST_S3);
   assign s4       = (q_reg.st == ST_S4);
   assign s5       = (q_reg.st == ST_S5);
   assign sleeping = s3 | s4 | s5;
   assign acc      = psel & penable & q_reg.pready;
   assign cmd_wr   = acc & pwrite & (paddr == OFS_SLEEP);
   assign quiet    = ac_s & !tm.short_rel & !tm.long_hold;
   // a level held across sleep entry is not a new request
   assign wk_edge  = wk_s & ~q_reg.wk_prev;

   // wake gating per source and state
   assign wake_ok[WK_RTC]  = wk_edge[WK_RTC] & sleeping;
   assign wake_ok[WK_LAN]  = wk_edge[WK_LAN] & sleeping;
   assign wake_ok[WK_USB]  = wk_edge[WK_USB] & (s3 | ((s4 | s5) &
                             q_reg.ctrl[CB_USB_EN] & !q_reg.after_g3 &
                             !q_reg.ctrl[CB_DEEP]));
   assign wake_ok[WK_PCIE] = wk_edge[WK_PCIE] & (s3 | s4);
   assign wake_ok[WK_IR]   = wk_edge[WK_IR] &
                             (s3 | ((s4 | s5) & !q_reg.ctrl[CB_DEEP]));

   ////////////////////////////////////////////////////////////////////////////
   // next state: power fsm, apb slave, status and outputs
   always_comb begin
      logic [3:0] set_b;
      logic [3:0] clr_b;
      set_b             = 4'h0;
      clr_b             = 4'h0;
      q_next            = q_reg;
      q_next.pready     = 1'b0;
      q_next.pslverr    = 1'b0;
      q_next.cold_boot  = 1'b0;
      q_next.resume     = 1'b0;
      q_next.wk_prev    = wk_s;

      // apb: answer one cycle into the access phase
      if (psel && penable && !q_reg.pready) begin
         q_next.pready = 1'b1;
         case (paddr)
            OFS_CTRL:  q_next.prdata = {28'h0000000, q_reg.ctrl};
            OFS_SLEEP: begin
               case (q_reg.st)
                  ST_S0:   q_next.prdata = {29'h00000000, STC_S0};
                  ST_S3:   q_next.prdata = {29'h00000000, STC_S3};
                  ST_S4:   q_next.prdata = {29'h00000000, STC_S4};
                  ST_S5:   q_next.prdata = {29'h00000000, STC_S5};
                  default: q_next.prdata = {29'h00000000, STC_G3};
               endcase
            end
            OFS_STAT:  q_next.prdata = {28'h0000000, q_reg.stat};
            OFS_MASK:  q_next.prdata = {28'h0000000, q_reg.mask};
            OFS_WSRC:  q_next.prdata = {27'h0000000, q_reg.wsrc};
            default: begin
               // unmapped: error answer, zero data
               q_next.prdata  = 32'h00000000;
               q_next.pslverr = 1'b1;
            end
         endcase
      end
      // apb writes take effect at the completing edge
      if (acc && pwrite) begin
         case (paddr)
            OFS_CTRL: q_next.ctrl = pwdata[3:0];
            OFS_STAT: clr_b = pwdata[3:0];
            OFS_MASK: q_next.mask = pwdata[3:0];
            default: ;
         endcase
      end

      // power state machine
      if (!ac_s && q_reg.st != ST_G3) begin
         // ac lost: remember whether the system was on
         q_next.st      = ST_G3;
         q_next.last_on = (q_reg.st == ST_S0);
      end else begin
         case (q_reg.st)
            ST_G3: begin
               // presses are ignored here
               if (ac_s) begin
                  set_b[SB_ACRET] = 1'b1;
                  if (q_reg.ctrl[CB_RESTORE] && q_reg.last_on) begin
                     q_next.st        = ST_S0;
                     q_next.cold_boot = 1'b1;
                  end else begin
                     q_next.st       = ST_S5;
                     q_next.after_g3 = 1'b1;
                  end
               end
            end
            ST_S0: begin
               if (tm.long_hold) begin
                  // fail-safe off with no os handshake
                  q_next.st        = ST_S5;
                  set_b[SB_FORCED] = 1'b1;
               end else begin
                  if (tm.short_rel && q_reg.ctrl[CB_BTN_SLP])
                     set_b[SB_SLPREQ] = 1'b1;
                  // os sleep entry; other codes are ignored
                  if (cmd_wr) begin
                     case (pwdata[2:0])
                        STC_S3:  q_next.st = ST_S3;
                        STC_S4:  q_next.st = ST_S4;
                        STC_S5:  q_next.st = ST_S5;
                        default: ;
                     endcase
                  end
               end
            end
            ST_S3, ST_S4, ST_S5: begin
               if (tm.long_hold && !s5) begin
                  q_next.st = ST_S5;
               end else if (tm.short_rel) begin
                  q_next.st         = ST_S0;
                  q_next.display_on = 1'b1;
               end else if (|wake_ok) begin
                  q_next.st      = ST_S0;
                  set_b[SB_WAKE] = 1'b1;
                  q_next.wsrc    = wake_ok;
                  // rtc, network and pcie keep the monitor dark
                  q_next.display_on = wake_ok[WK_USB] | wake_ok[WK_IR];
               end
               // no context in s5, so it boots cold
               if (q_next.st == ST_S0) begin
                  q_next.cold_boot = s5;
                  q_next.resume    = !s5;
               end
            end
            default: q_next.st = ST_G3;
         endcase
      end
      if (q_next.st == ST_S0) q_next.after_g3 = 1'b0;
      if (q_next.st != ST_S0) q_next.display_on = 1'b0;
      if (q_reg.st == ST_G3 && q_next.st == ST_S0) q_next.display_on = 1'b1;

      // sticky status: a set in the clearing cycle survives
      q_next.stat = (q_reg.stat & ~clr_b) | set_b;
      q_next.irq  = |(q_next.stat & q_next.mask);
      // rails: processor only in s0, ram kept in s3 for context
      q_next.cpu_pwr = (q_next.st == ST_S0);
      q_next.ram_pwr = (q_next.st == ST_S0) | (q_next.st == ST_S3);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q_reg <= CTL_RST;
      else q_reg <= q_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign prdata     = q_reg.prdata;
   assign pready     = q_reg.pready;
   assign pslverr    = q_reg.pslverr;
   assign cpu_pwr_en = q_reg.cpu_pwr;
   assign ram_pwr_en = q_reg.ram_pwr;
   assign cold_boot  = q_reg.cold_boot;
   assign resume     = q_reg.resume;
   assign display_on = q_reg.display_on;
   assign irq        = q_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_short_wakes: assert property (@(posedge pclk) disable iff (!presetn)
      (sleeping && ac_s && tm.short_rel) |=> q_reg.st == ST_S0)
      else $error("short press did not wake");
   a_short_sleep_req: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st == ST_S0 && quiet == 1'b0 && ac_s && tm.short_rel &&
       q_reg.ctrl[CB_BTN_SLP]) |=> q_reg.stat[SB_SLPREQ])
      else $error("short press in s0 raised no sleep request");
   a_forced_off: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st == ST_S0 && ac_s && tm.long_hold) |=>
      (q_reg.st == ST_S5 && q_reg.stat[SB_FORCED] && !q_reg.cpu_pwr))
      else $error("long hold in s0 did not force soft-off");
   a_sleep_to_off: assert property (@(posedge pclk) disable iff (!presetn)
      ((s3 || s4) && ac_s && tm.long_hold) |=> q_reg.st == ST_S5)
      else $error("long hold asleep did not reach s5");
   a_cold_from_s5: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(q_reg.st) == ST_S5 && q_reg.st == ST_S0) |->
      (q_reg.cold_boot && !q_reg.resume))
      else $error("exit from s5 without cold boot");
   a_cpu_dark: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st != ST_S0) |-> (!cpu_pwr_en && !(s4 && ram_pwr_en)))
      else $error("processor or ram powered while asleep");
   a_rtc_dark: assert property (@(posedge pclk) disable iff (!presetn)
      (sleeping && quiet && wake_ok == 5'h01) |=>
      (q_reg.st == ST_S0 && !display_on) ##1 !display_on)
      else $error("rtc wake lit the monitor");
   a_usb_deep: assert property (@(posedge pclk) disable iff (!presetn)
      ((s4 || s5) && q_reg.ctrl[CB_DEEP] && quiet && wk_edge == 5'h04)
      |=> $stable(q_reg.st))
      else $error("usb woke deep sleep");
   a_pcie_s5: assert property (@(posedge pclk) disable iff (!presetn)
      (s5 && quiet && wk_edge == 5'h08) |=> q_reg.st == ST_S5)
      else $error("pcie wake left s5");
   a_ac_restore: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st == ST_G3 && ac_s && q_reg.ctrl[CB_RESTORE] && q_reg.last_on)
      |=> (q_reg.st == ST_S0 && q_reg.cold_boot))
      else $error("last on state not restored");
   a_g3_still: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st == ST_G3 && !ac_s) |=> q_reg.st == ST_G3)
      else $error("left g3 without ac");
   a_work_discard: assert property (@(posedge pclk) disable iff (!presetn)
      (q_reg.st == ST_S0 && quiet && !cmd_wr) |=>
      (q_reg.st == ST_S0 && $stable(q_reg.wsrc)))
      else $error("wake request acted on in s0");
endmodule // bpswc_top
`default_nettype wire

// *** bpswc_far_model.sv ***
// far side model: power switch, ac supply and wake request pins
`timescale 1ns/1ps
`default_nettype none
module bpswc_far_model (
   // clock
   input  wire logic       pclk,
   // board pins, the switch is low while pressed
   output logic            pwr_btn_n,
   output logic            ac_present,
   output logic [4:0]      wk
);
   // idle levels: switch released, mains present, no requests
   initial begin
      pwr_btn_n  <= 1'b1;
      ac_present <= 1'b1;
      wk         <= 5'h00;
   end
   // hold the switch n clocks; length decides short, mid or long
   task press(input int n);
      @(posedge pclk) pwr_btn_n <= 1'b0;
      repeat (n) @(posedge pclk);
      pwr_btn_n <= 1'b1;
   endtask
   // request pulse kept past the pin filter, then dropped again
   task pulse(input int s);
      @(posedge pclk) wk[s] <= 1'b1;
      repeat (6) @(posedge pclk);
      wk[s] <= 1'b0;
   endtask
   // mains supply on or off
   task supply(input logic on);
      @(posedge pclk) ac_present <= on;
   endtask
endmodule // bpswc_far_model
`default_nettype wire

// *** bpswc_top_tb.sv ***
// self-checking bench of the power state and wake controller
`timescale 1ns/1ps
`default_nettype none
module bpswc_top_tb;
   import bpswc_pkg::*;
   logic pclk = 0;
   logic presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, cpu_pwr_en, ram_pwr_en, cold_boot, resume;
   logic display_on, irq, pwr_btn_n, ac_present;
   logic [4:0] wk;
   logic [1:0] c;
   logic ok;
   int num_errors = 0, checked = 0, cyc = 0, seed = 6, ncold = 0;
   int nres = 0, n0, n1;
   always #12.5 pclk = ~pclk;
   bpswc_top #(.TICK_CYC_P(16'h0004), .SHORT_TICKS_P(13'h0004),
      .LONG_TICKS_P(13'h0006)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_btn_n(pwr_btn_n), .ac_present(ac_present), .rtc_alarm(wk[0]),
      .network_wake(wk[1]), .usb_wake(wk[2]), .pcie_wake_n(~wk[3]),
      .infrared_remote_wake(wk[4]), .cpu_pwr_en(cpu_pwr_en),
      .ram_pwr_en(ram_pwr_en), .cold_boot(cold_boot), .resume(resume),
      .display_on(display_on), .irq(irq));
   bpswc_far_model u_far (.pclk(pclk), .pwr_btn_n(pwr_btn_n),
      .ac_present(ac_present), .wk(wk));
   // cold boot pulse count and hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cold_boot === 1'b1) ncold++;
      if (resume === 1'b1) nres++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run;
      end
   end
   task complete_run;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for pready, read data lands in rd
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      // only the cycle guard ends a wait that never completes
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task w(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task st(input logic [2:0] e);
      apb(1'b0, OFS_SLEEP, 32'h0);
      chk(rd, {29'h0, e});
   endtask
   // is source s taken from sleep state t with usb enable / deep bits c
   function logic acc(int s, int t, logic [1:0] c);
      case (s)
         WK_RTC, WK_LAN: acc = 1'b1;
         WK_USB: acc = (t == 3) || (c == 2'b01);
         WK_PCIE: acc = (t != 5);
         default: acc = (t == 3) || !c[1];
      endcase
   endfunction
   initial begin
      // idle bus with random address and data, ignored while psel is low
      presetn <= 1'b0;
      {psel, penable, pwrite} <= 3'b000;
      paddr  <= 12'($random(seed));
      pwdata <= $random(seed);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      w(10);
      st(STC_S5);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      u_far.press(4 + {$random(seed)} % 8);
      w(12);
      st(STC_S0);
      chk({ncold[29:0], cpu_pwr_en, display_on}, {30'h1, 2'b11});
      apb(1'b1, OFS_CTRL, 32'h8);
      apb(1'b1, OFS_MASK, 32'h1);
      u_far.press(5);
      w(12);
      st(STC_S0);
      chk(irq, 1'b1);
      apb(1'b1, OFS_STAT, 32'h1);
      w(2);
      chk(irq, 1'b0);
      u_far.pulse(WK_RTC);
      apb(1'b1, OFS_SLEEP, 32'h3);
      w(12);
      st(STC_S3);
      u_far.press(5);
      w(12);
      for (int s = 0; s < NWAKE; s++)
         for (int t = 3; t < 6; t++) begin
            c = 2'($random(seed));
            apb(1'b1, OFS_CTRL, {28'h0, 2'b10, c});
            apb(1'b1, OFS_SLEEP, 32'(t));
            w(2);
            chk({cpu_pwr_en, ram_pwr_en}, {1'b0, t == 3});
            n0 = ncold;
            n1 = nres;
            u_far.pulse(s);
            w(12);
            ok = acc(s, t, c);
            st(ok ? STC_S0 : 3'(t));
            if (ok) begin
               chk(display_on, s == WK_USB || s == WK_IR);
               chk(ncold - n0, 32'(t == 5));
               chk(nres - n1, 32'(t != 5));
               apb(1'b0, OFS_WSRC, 32'h0);
               chk(rd, 32'h1 << s);
            end else begin
               u_far.press(6);
               w(12);
            end
         end
      u_far.press(40);
      w(8);
      st(STC_S5);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[2], 1'b1);
      u_far.press(21);
      w(12);
      st(STC_S5);
      u_far.press(5);
      w(12);
      apb(1'b1, OFS_SLEEP, 32'h3);
      u_far.press(40);
      w(8);
      st(STC_S5);
      u_far.press(5);
      w(12);
      apb(1'b1, OFS_CTRL, 32'h4);
      u_far.supply(1'b0);
      w(8);
      st(STC_G3);
      u_far.press(5);
      w(12);
      st(STC_G3);
      u_far.supply(1'b1);
      w(12);
      st(STC_S0);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      // usb may not wake s5 after ac loss, network may
      apb(1'b1, OFS_CTRL, 32'h1);
      u_far.supply(1'b0);
      w(8);
      u_far.supply(1'b1);
      w(12);
      u_far.pulse(WK_USB);
      w(12);
      st(STC_S5);
      u_far.pulse(WK_LAN);
      w(12);
      st(STC_S0);
      complete_run;
   end
endmodule // bpswc_top_tb
`default_nettype wire
